// ===== logic/acr_pkg.sv
// constants for the converter configuration register bank
package acr_pkg;
  // serial register addresses
  localparam logic [7:0] ADDR_RST   = 8'h00;
  localparam logic [7:0] ADDR_SWING = 8'h01;
  localparam logic [7:0] ADDR_PERF  = 8'h03;
  localparam logic [7:0] ADDR_CHA   = 8'h25;
  localparam logic [7:0] ADDR_FMT   = 8'h29;
  localparam logic [7:0] ADDR_CHB   = 8'h2b;
  localparam logic [7:0] ADDR_OFS   = 8'h3d;
  localparam logic [7:0] ADDR_CPH   = 8'h3f;
  localparam logic [7:0] ADDR_CPL   = 8'h40;
  localparam logic [7:0] ADDR_IFC   = 8'h41;
  localparam logic [7:0] ADDR_EDGE  = 8'h42;
  localparam logic [7:0] ADDR_STANDBY_AND_DRIVE_STRENGTH  = 8'h45;
  localparam logic [7:0] ADDR_SWEN  = 8'hf1;
  // storage slots, one per address above
  localparam int NUM_SLOTS  = 13;
  localparam logic [3:0] SLOT_RST   = 4'h0;
  localparam logic [3:0] SLOT_SWING = 4'h1;
  localparam logic [3:0] SLOT_PERF  = 4'h2;
  localparam logic [3:0] SLOT_CHA   = 4'h3;
  localparam logic [3:0] SLOT_FMT   = 4'h4;
  localparam logic [3:0] SLOT_CHB   = 4'h5;
  localparam logic [3:0] SLOT_OFS   = 4'h6;
  localparam logic [3:0] SLOT_CPH   = 4'h7;
  localparam logic [3:0] SLOT_CPL   = 4'h8;
  localparam logic [3:0] SLOT_IFC   = 4'h9;
  localparam logic [3:0] SLOT_EDGE  = 4'ha;
  localparam logic [3:0] SLOT_STANDBY_AND_DRIVE_STRENGTH  = 4'hb;
  localparam logic [3:0] SLOT_SWEN  = 4'hc;
  // writable bits per slot; reserved bits are never stored
  localparam logic [7:0] SLOT_MASK [NUM_SLOTS] = '{
    8'h01, 8'hfc, 8'h03, 8'hf7, 8'h18, 8'hf7, 8'h20,
    8'h3f, 8'hff, 8'hf3, 8'hf8, 8'hc0, 8'h03};
  localparam logic [7:0] REG_RESET = 8'h00;
  // field positions
  localparam int RDOUT_BIT  = 0;
  localparam int RST_BIT    = 1;
  localparam int SWING_LSB  = 2;
  localparam int GAIN_LSB   = 4;
  localparam int PAT_LSB    = 0;
  localparam int FMT_LSB    = 3;
  localparam int OFS_BIT    = 5;
  localparam int IFC_LSB    = 6;
  localparam int SEDRV_LSB  = 4;
  localparam int DIS_LSB    = 0;
  localparam int FALL_LSB   = 6;
  localparam int RISE_LSB   = 4;
  localparam int DIG_BIT    = 3;
  localparam int STANDBY_AND_DRIVE_STRENGTH_BIT   = 7;
  localparam int DDRV_BIT   = 6;
  // field codes
  localparam logic [2:0] PAT_NORMAL = 3'h0;
  localparam logic [2:0] PAT_ZEROS  = 3'h1;
  localparam logic [2:0] PAT_ONES   = 3'h2;
  localparam logic [2:0] PAT_TOGGLE = 3'h3;
  localparam logic [2:0] PAT_RAMP   = 3'h4;
  localparam logic [2:0] PAT_CUSTOM = 3'h5;
  localparam logic [1:0] FMT_OFFBIN = 2'h3;
  localparam logic [1:0] IFC_CMOS   = 2'h3;
  localparam logic [1:0] DIS_ALL    = 2'h3;
  localparam logic [1:0] SWEN_ON    = 2'h3;
  localparam logic [13:0] TOGGLE_A  = 14'h2aaa;
  localparam logic [13:0] TOGGLE_B  = 14'h1555;
  // gain: 0.5 dB steps as Q12 multipliers, codes 0 to 12
  localparam logic [3:0] GAIN_MAX_CODE = 4'hc;
  localparam logic [13:0] GAIN_COEF [13] = '{
    14'h1000, 14'h10f4, 14'h11f4, 14'h1305, 14'h1425, 14'h1556,
    14'h169a, 14'h17f1, 14'h195c, 14'h1add, 14'h1c74, 14'h1e24,
    14'h1fed};
  localparam int GAIN_FRAC = 12;
  localparam logic signed [16:0] SAT_MAX = 17'sh01fff;
  localparam logic signed [16:0] SAT_MIN = -17'sh02000;
  // offset estimate: 6 fraction bits, loop shift 6
  localparam int OFS_FRAC  = 6;
  localparam int OFS_SHIFT = 6;
  // serial frame: 8 address then 8 data bits
  localparam logic [4:0] ADDR_LAST  = 5'h07;
  localparam logic [4:0] FRAME_LAST = 5'h0f;
  // standby wakeup time
  localparam int CLK_MHZ  = 25;
  localparam int WAKE_US  = 50;
  localparam int WAKE_CYC = WAKE_US * CLK_MHZ;
endpackage : acr_pkg

// ===== logic/acr_top.sv
// serially programmed configuration bank and output data path
`timescale 1ns/1ps
// What this block does
// - soft reset bit clears registers, self-clears
// - every register resets to zero
// - one write updates all fields of the addressed register
// - readout off tri-states serial output pin
// - per-channel gain, 0.5 dB steps to 6 dB
// - pattern codes: normal, zeros, ones
// - toggle pattern alternates 1010 and 0101
// - ramp pattern counts up, wraps at 16383
// - custom pattern from two registers
// - offset correction enable bit
// - interface select 11 means CMOS
// - CMOS clock drive strength code
// - buffer disable tri-states channels and clock
// - LVDS falling edge shift code
// - LVDS rising edge shift code
// - digital enable gates patterns, gain, offset
// - standby bit, wakeup about 50 us
// - LVDS clock drive strength bit
// - read cycle shifts out eight data bits
module acr_top #(
  parameter int WAKE_CYCLES = acr_pkg::WAKE_CYC
) (
  // clock and reset
  input  wire logic        CLK,
  input  wire logic        RESETN,
  // serial configuration port
  input  wire logic        SEN_N,
  input  wire logic        SCLK,
  input  wire logic        SDATA,
  output logic             SERIAL_OUT_PIN_O,
  output logic             SERIAL_OUT_PIN_OE,
  // conversion samples from the core
  input  wire logic [13:0] CHA_RAW,
  input  wire logic [13:0] CHB_RAW,
  input  wire logic        RAW_VALID,
  output logic             RAW_READY,
  // output words toward the capture logic
  output logic [13:0]      CHA_DATA,
  output logic [13:0]      CHB_DATA,
  output logic             DATA_VALID,
  input  wire logic        DATA_READY,
  // analog and pad controls
  output logic [5:0]       SWING_CODE,
  output logic [1:0]       BEST_PERFORMANCE_MODE,
  output logic             CMOS_SEL,
  output logic [1:0]       SINGLE_ENDED_CLOCK_DRIVE,
  output logic             CHA_OUT_OE,
  output logic             CHB_OUT_OE,
  output logic             CLKOUT_OE,
  output logic [1:0]       OUT_CLOCK_FALL_SHIFT,
  output logic [1:0]       OUT_CLOCK_RISE_SHIFT,
  output logic             DIFF_CLOCK_DRIVE,
  output logic             OFFSET_FIX_ON,
  output logic             STANDBY,
  output logic             AWAKE
);

  typedef enum logic {SER_SHIFT, SER_HOLD} acr_ser_t;
  typedef enum logic [1:0] {PWR_RUN, PWR_SLEEP, PWR_WAKE} acr_pwr_t;

  // reset release synchroniser
  logic rst_meta_q;
  logic rst_n_q;
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      rst_meta_q <= 1'b0;
      rst_n_q    <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_n_q    <= rst_meta_q;
    end
  end

  // serial pins pass two flip-flops, sclk keeps a third for edges
  logic sen_s1_q, sen_s2_q;
  logic sclk_s1_q, sclk_s2_q, sclk_s3_q;
  logic sdat_s1_q, sdat_s2_q;
  always_ff @(posedge CLK or negedge rst_n_q) begin
    if (!rst_n_q) begin
      sen_s1_q  <= 1'b1;
      sen_s2_q  <= 1'b1;
      sclk_s1_q <= 1'b0;
      sclk_s2_q <= 1'b0;
      sclk_s3_q <= 1'b0;
      sdat_s1_q <= 1'b0;
      sdat_s2_q <= 1'b0;
    end else begin
      sen_s1_q  <= SEN_N;
      sen_s2_q  <= sen_s1_q;
      sclk_s1_q <= SCLK;
      sclk_s2_q <= sclk_s1_q;
      sclk_s3_q <= sclk_s2_q;
      sdat_s1_q <= SDATA;
      sdat_s2_q <= sdat_s1_q;
    end
  end

  // register storage, one byte per mapped address
  logic [7:0] cfg_q [acr_pkg::NUM_SLOTS];

  // address to storage slot decode, bit 4 marks a hit
  function automatic logic [4:0] slot_of(input logic [7:0] a);
    case (a)
      acr_pkg::ADDR_RST:   slot_of = {1'b1, acr_pkg::SLOT_RST};
      acr_pkg::ADDR_SWING: slot_of = {1'b1, acr_pkg::SLOT_SWING};
      acr_pkg::ADDR_PERF:  slot_of = {1'b1, acr_pkg::SLOT_PERF};
      acr_pkg::ADDR_CHA:   slot_of = {1'b1, acr_pkg::SLOT_CHA};
      acr_pkg::ADDR_FMT:   slot_of = {1'b1, acr_pkg::SLOT_FMT};
      acr_pkg::ADDR_CHB:   slot_of = {1'b1, acr_pkg::SLOT_CHB};
      acr_pkg::ADDR_OFS:   slot_of = {1'b1, acr_pkg::SLOT_OFS};
      acr_pkg::ADDR_CPH:   slot_of = {1'b1, acr_pkg::SLOT_CPH};
      acr_pkg::ADDR_CPL:   slot_of = {1'b1, acr_pkg::SLOT_CPL};
      acr_pkg::ADDR_IFC:   slot_of = {1'b1, acr_pkg::SLOT_IFC};
      acr_pkg::ADDR_EDGE:  slot_of = {1'b1, acr_pkg::SLOT_EDGE};
      acr_pkg::ADDR_STANDBY_AND_DRIVE_STRENGTH:  slot_of = {1'b1, acr_pkg::SLOT_STANDBY_AND_DRIVE_STRENGTH};
      acr_pkg::ADDR_SWEN:  slot_of = {1'b1, acr_pkg::SLOT_SWEN};
      default:             slot_of = 5'h00;
    endcase
  endfunction : slot_of

  // serial frame state
  acr_ser_t   ser_q, ser_d;
  logic [4:0] cnt_q, cnt_d;
  logic [14:0] sh_q, sh_d;
  logic [7:0] out_sh_q, out_sh_d;

  // serial event decode
  wire       sen_act    = ~sen_s2_q;
  wire       sclk_rise  = sclk_s2_q & ~sclk_s3_q;
  wire       bit_take   = sen_act & sclk_rise & (ser_q == SER_SHIFT);
  wire       addr_done  = bit_take & (cnt_q == acr_pkg::ADDR_LAST);
  wire       frame_done = bit_take & (cnt_q == acr_pkg::FRAME_LAST);
  wire       readout    = cfg_q[acr_pkg::SLOT_RST][acr_pkg::RDOUT_BIT];
  wire [7:0] rd_addr    = {sh_q[6:0], sdat_s2_q};
  wire [4:0] rd_slot    = slot_of(rd_addr);
  wire [7:0] rd_byte    = rd_slot[4] ? cfg_q[rd_slot[3:0]] : 8'h00;
  wire [7:0] wr_addr    = sh_q[14:7];
  wire [7:0] wr_data    = {sh_q[6:0], sdat_s2_q};
  wire [4:0] wr_slot    = slot_of(wr_addr);
  wire       wr_go      = frame_done & ~readout & wr_slot[4];
  wire       wr_soft    = wr_go & (wr_slot[3:0] == acr_pkg::SLOT_RST)
                        & wr_data[acr_pkg::RST_BIT];

  // frame counter, input shifter and readout shifter
  always_comb begin
    ser_d    = ser_q;
    cnt_d    = cnt_q;
    sh_d     = sh_q;
    out_sh_d = out_sh_q;
    if (!sen_act) begin
      ser_d    = SER_SHIFT;
      cnt_d    = 5'h00;
      out_sh_d = 8'h00;
    end else if (bit_take) begin
      sh_d  = {sh_q[13:0], sdat_s2_q};
      cnt_d = cnt_q + 5'h01;
      if (frame_done) begin
        ser_d = SER_HOLD;
      end
      if (addr_done) begin
        out_sh_d = readout ? rd_byte : 8'h00;
      end else if (cnt_q > acr_pkg::ADDR_LAST) begin
        out_sh_d = {out_sh_q[6:0], 1'b0};
      end
    end
  end

  // serial state registers
  always_ff @(posedge CLK or negedge rst_n_q) begin
    if (!rst_n_q) begin
      ser_q    <= SER_SHIFT;
      cnt_q    <= 5'h00;
      sh_q     <= 15'h0000;
      out_sh_q <= 8'h00;
    end else begin
      ser_q    <= ser_d;
      cnt_q    <= cnt_d;
      sh_q     <= sh_d;
      out_sh_q <= out_sh_d;
    end
  end

  // register writes: whole byte at once, soft reset clears all
  always_ff @(posedge CLK or negedge rst_n_q) begin
    if (!rst_n_q) begin
      for (int i = 0; i < acr_pkg::NUM_SLOTS; i++) begin
        cfg_q[i] <= acr_pkg::REG_RESET;
      end
    end else if (wr_soft) begin
      for (int i = 0; i < acr_pkg::NUM_SLOTS; i++) begin
        cfg_q[i] <= acr_pkg::REG_RESET;
      end
    end else if (wr_go) begin
      cfg_q[wr_slot[3:0]] <= wr_data
                           & acr_pkg::SLOT_MASK[wr_slot[3:0]];
    end
  end

  // serial output pin, driven only while readout is on
  assign SERIAL_OUT_PIN_O  = out_sh_q[7];
  assign SERIAL_OUT_PIN_OE = readout;

  // field views
  wire [3:0] gain_a  = cfg_q[acr_pkg::SLOT_CHA][acr_pkg::GAIN_LSB +: 4];
  wire [2:0] pat_a   = cfg_q[acr_pkg::SLOT_CHA][acr_pkg::PAT_LSB +: 3];
  wire [3:0] gain_b  = cfg_q[acr_pkg::SLOT_CHB][acr_pkg::GAIN_LSB +: 4];
  wire [2:0] pat_b   = cfg_q[acr_pkg::SLOT_CHB][acr_pkg::PAT_LSB +: 3];
  wire [1:0] fmt     = cfg_q[acr_pkg::SLOT_FMT][acr_pkg::FMT_LSB +: 2];
  wire       dig_en  = cfg_q[acr_pkg::SLOT_EDGE][acr_pkg::DIG_BIT];
  wire       ofs_en  = cfg_q[acr_pkg::SLOT_OFS][acr_pkg::OFS_BIT];
  wire       ofs_on  = dig_en & ofs_en;
  wire       off_bin = (fmt == acr_pkg::FMT_OFFBIN);
  wire [1:0] dis     = cfg_q[acr_pkg::SLOT_IFC][acr_pkg::DIS_LSB +: 2];
  wire [1:0] ifc     = cfg_q[acr_pkg::SLOT_IFC][acr_pkg::IFC_LSB +: 2];
  wire [1:0] swen    = cfg_q[acr_pkg::SLOT_SWEN][1:0];
  wire       standby_and_drive_strength    = cfg_q[acr_pkg::SLOT_STANDBY_AND_DRIVE_STRENGTH][acr_pkg::STANDBY_AND_DRIVE_STRENGTH_BIT];
  wire [13:0] custom = {cfg_q[acr_pkg::SLOT_CPH][5:0],
                        cfg_q[acr_pkg::SLOT_CPL]};

  // pattern sources shared by both channels, offset estimates per channel
  logic [13:0] ramp_q;
  logic        tog_q;
  logic signed [19:0] est_a_q, est_b_q;

  // clamp a wide signed value into 14 bits
  function automatic logic [13:0] sat14(input logic signed [16:0] v);
    if (v > acr_pkg::SAT_MAX) begin
      sat14 = 14'h1fff;
    end else if (v < acr_pkg::SAT_MIN) begin
      sat14 = 14'h2000;
    end else begin
      sat14 = v[13:0];
    end
  endfunction : sat14

  // one channel: offset fix, gain, format, then pattern override
  function automatic logic [13:0] chan_word(
    input logic [13:0]        raw,
    input logic signed [19:0] est,
    input logic [3:0]         gain,
    input logic [2:0]         pat
  );
    logic signed [16:0] diff;
    logic [13:0]        x;
    logic [13:0]        coef;
    logic signed [28:0] prod;
    logic [13:0]        w;
    diff = 17'($signed(raw)) - 17'($signed(est[19:acr_pkg::OFS_FRAC]));
    x    = ofs_on ? sat14(diff) : raw;
    coef = (gain <= acr_pkg::GAIN_MAX_CODE) ? acr_pkg::GAIN_COEF[gain]
                                            : acr_pkg::GAIN_COEF[0];
    prod = $signed(x) * $signed({1'b0, coef});
    w    = dig_en ? sat14(prod[28:acr_pkg::GAIN_FRAC]) : x;
    w    = off_bin ? {~w[13], w[12:0]} : w;
    chan_word = w;
    if (dig_en) begin
      case (pat)
        acr_pkg::PAT_ZEROS:  chan_word = 14'h0000;
        acr_pkg::PAT_ONES:   chan_word = 14'h3fff;
        acr_pkg::PAT_TOGGLE: chan_word = tog_q ? acr_pkg::TOGGLE_B
                                                : acr_pkg::TOGGLE_A;
        acr_pkg::PAT_RAMP:   chan_word = ramp_q;
        acr_pkg::PAT_CUSTOM: chan_word = custom;
        default:             chan_word = w;
      endcase
    end
  endfunction : chan_word

  // first-order offset estimate step
  function automatic logic signed [19:0] ofs_step(
    input logic signed [19:0] est,
    input logic [13:0]        raw
  );
    logic signed [20:0] d;
    d = $signed({raw[13], raw, 6'h00}) - $signed({est[19], est});
    ofs_step = est + 20'(d >>> acr_pkg::OFS_SHIFT);
  endfunction : ofs_step

  // standby sequencing
  acr_pwr_t   pwr_q;
  logic [15:0] wake_q;
  wire        awake = (pwr_q == PWR_RUN);

  // skid buffer: output stage plus one spare entry
  logic [13:0] out_a_q, out_b_q, sk_a_q, sk_b_q;
  logic        out_v_q, sk_v_q, in_rdy_q;
  wire  [13:0] word_a   = chan_word(CHA_RAW, est_a_q, gain_a, pat_a);
  wire  [13:0] word_b   = chan_word(CHB_RAW, est_b_q, gain_b, pat_b);
  wire         take     = RAW_VALID & in_rdy_q;
  wire         out_load = ~out_v_q | DATA_READY;
  wire         sk_v_d   = out_load ? 1'b0 : (sk_v_q | take);

  // buffer registers, receiver stall parks one word in the spare
  always_ff @(posedge CLK or negedge rst_n_q) begin
    if (!rst_n_q) begin
      out_v_q  <= 1'b0;
      sk_v_q   <= 1'b0;
      in_rdy_q <= 1'b0;
      out_a_q  <= 14'h0000;
      out_b_q  <= 14'h0000;
      sk_a_q   <= 14'h0000;
      sk_b_q   <= 14'h0000;
    end else begin
      sk_v_q   <= sk_v_d;
      in_rdy_q <= ~sk_v_d & awake;
      if (out_load) begin
        out_v_q <= sk_v_q | take;
        out_a_q <= sk_v_q ? sk_a_q : word_a;
        out_b_q <= sk_v_q ? sk_b_q : word_b;
      end else if (take) begin
        sk_a_q <= word_a;
        sk_b_q <= word_b;
      end
    end
  end

  // pattern and offset state advance once per sample taken
  always_ff @(posedge CLK or negedge rst_n_q) begin
    if (!rst_n_q) begin
      ramp_q  <= 14'h0000;
      tog_q   <= 1'b0;
      est_a_q <= 20'sh00000;
      est_b_q <= 20'sh00000;
    end else if (take) begin
      ramp_q  <= ramp_q + 14'h0001;
      tog_q   <= ~tog_q;
      if (ofs_on) begin
        est_a_q <= ofs_step(est_a_q, CHA_RAW);
        est_b_q <= ofs_step(est_b_q, CHB_RAW);
      end
    end
  end

  // standby state machine with wakeup delay
  always_ff @(posedge CLK or negedge rst_n_q) begin
    if (!rst_n_q) begin
      pwr_q  <= PWR_RUN;
      wake_q <= 16'h0000;
    end else begin
      case (pwr_q)
        PWR_RUN: begin
          if (standby_and_drive_strength) begin
            pwr_q <= PWR_SLEEP;
          end
        end
        PWR_SLEEP: begin
          wake_q <= 16'h0000;
          if (!standby_and_drive_strength) begin
            pwr_q <= PWR_WAKE;
          end
        end
        PWR_WAKE: begin
          wake_q <= wake_q + 16'h0001;
          if (standby_and_drive_strength) begin
            pwr_q <= PWR_SLEEP;
          end else if (wake_q == 16'(WAKE_CYCLES - 1)) begin
            pwr_q <= PWR_RUN;
          end
        end
        default: pwr_q <= PWR_RUN;
      endcase
    end
  end

  // registered pad and analog controls
  always_ff @(posedge CLK or negedge rst_n_q) begin
    if (!rst_n_q) begin
      SWING_CODE    <= 6'h00;
      CMOS_SEL      <= 1'b0;
      CHA_OUT_OE    <= 1'b1;
      CHB_OUT_OE    <= 1'b1;
      CLKOUT_OE     <= 1'b1;
      OFFSET_FIX_ON <= 1'b0;
      STANDBY       <= 1'b0;
      AWAKE         <= 1'b1;
    end else begin
      SWING_CODE    <= (swen == acr_pkg::SWEN_ON)
                     ? cfg_q[acr_pkg::SLOT_SWING][acr_pkg::SWING_LSB +: 6]
                     : 6'h00;
      CMOS_SEL      <= (ifc == acr_pkg::IFC_CMOS);
      CHA_OUT_OE    <= ~dis[1];
      CHB_OUT_OE    <= ~dis[0];
      CLKOUT_OE     <= (dis != acr_pkg::DIS_ALL);
      OFFSET_FIX_ON <= ofs_on;
      STANDBY       <= (pwr_q == PWR_SLEEP);
      AWAKE         <= awake;
    end
  end

  // fields that leave the block straight from storage
  assign BEST_PERFORMANCE_MODE    = cfg_q[acr_pkg::SLOT_PERF][1:0];
  assign SINGLE_ENDED_CLOCK_DRIVE =
    cfg_q[acr_pkg::SLOT_IFC][acr_pkg::SEDRV_LSB +: 2];
  assign OUT_CLOCK_FALL_SHIFT =
    cfg_q[acr_pkg::SLOT_EDGE][acr_pkg::FALL_LSB +: 2];
  assign OUT_CLOCK_RISE_SHIFT =
    cfg_q[acr_pkg::SLOT_EDGE][acr_pkg::RISE_LSB +: 2];
  assign DIFF_CLOCK_DRIVE =
    cfg_q[acr_pkg::SLOT_STANDBY_AND_DRIVE_STRENGTH][acr_pkg::DDRV_BIT];

  // data and status outputs
  assign CHA_DATA   = out_a_q;
  assign CHB_DATA   = out_b_q;
  assign DATA_VALID = out_v_q;
  assign RAW_READY  = in_rdy_q;

endmodule : acr_top

// ===== verif/acr_checker_assertions.sv
// port-level checks for the configuration bank and data path
`timescale 1ns/1ps
module acr_checker #(
  parameter int WAKE_CYCLES = 8
) (
  // clock and reset
  input wire logic        CLK,
  input wire logic        RESETN,
  // serial port
  input wire logic        SEN_N,
  input wire logic        SERIAL_OUT_PIN_O,
  input wire logic        SERIAL_OUT_PIN_OE,
  // data path
  input wire logic        RAW_VALID,
  input wire logic        RAW_READY,
  input wire logic [13:0] CHA_DATA,
  input wire logic [13:0] CHB_DATA,
  input wire logic        DATA_VALID,
  input wire logic        DATA_READY,
  // pad and power controls
  input wire logic        CHA_OUT_OE,
  input wire logic        CHB_OUT_OE,
  input wire logic        CLKOUT_OE,
  input wire logic        STANDBY,
  input wire logic        AWAKE
);
  localparam int WAKE_LO = WAKE_CYCLES - 3;
  localparam int WAKE_HI = WAKE_CYCLES + 3;

  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RESETN);

  // steps of the reset release and of a stalled output
  sequence s_held_low;
    !RAW_READY [*3];
  endsequence
  sequence s_stall;
    DATA_VALID && !DATA_READY;
  endsequence

  // words and handshake
  a_stall_hold_words: assert property (s_stall |=> DATA_VALID &&
    $stable(CHA_DATA) && $stable(CHB_DATA))
    else $error("output words changed while stalled");
  a_take_to_out: assert property (RAW_VALID && RAW_READY && !DATA_VALID
    |=> DATA_VALID) else $error("taken sample did not reach output");
  a_reset_release: assert property ($rose(RESETN) |->
    s_held_low ##1 RAW_READY)
    else $error("ready after reset release mistimed");
  // pins
  a_pin_needs_enable: assert property (
    SERIAL_OUT_PIN_O |-> SERIAL_OUT_PIN_OE)
    else $error("serial pin data without enable");
  a_pin_idle_low: assert property (
    $rose(SEN_N) |-> ##5 !SERIAL_OUT_PIN_O)
    else $error("serial pin not idle after frame");
  a_clk_off_all: assert property (
    !CLKOUT_OE |-> !CHA_OUT_OE && !CHB_OUT_OE)
    else $error("clock buffer off while data buffers on");
  // standby
  a_standby_no_take: assert property (STANDBY |=> !RAW_READY)
    else $error("sample accepted in standby");
  a_sleep_not_awake: assert property (STANDBY |=> !AWAKE)
    else $error("awake flag high in standby");
  a_wake_delay: assert property (
    $fell(STANDBY) |-> ##[WAKE_LO:WAKE_HI] $rose(AWAKE))
    else $error("wakeup time wrong");
endmodule : acr_checker

bind acr_top acr_checker #(.WAKE_CYCLES(WAKE_CYCLES)) i_chk (
  .CLK(CLK), .RESETN(RESETN), .SEN_N(SEN_N),
  .SERIAL_OUT_PIN_O(SERIAL_OUT_PIN_O), .SERIAL_OUT_PIN_OE(SERIAL_OUT_PIN_OE),
  .RAW_VALID(RAW_VALID), .RAW_READY(RAW_READY), .CHA_DATA(CHA_DATA),
  .CHB_DATA(CHB_DATA), .DATA_VALID(DATA_VALID), .DATA_READY(DATA_READY),
  .CHA_OUT_OE(CHA_OUT_OE), .CHB_OUT_OE(CHB_OUT_OE), .CLKOUT_OE(CLKOUT_OE),
  .STANDBY(STANDBY), .AWAKE(AWAKE));

// ===== verif/acr_host.sv
// serial host model driving the configuration port
`timescale 1ns/1ps
module acr_host (
  // serial port
  output logic sen_n,
  output logic sclk,
  output logic sdata,
  input  wire  sdo
);
  // link idle: enable high, clock parked low
  initial begin
    sen_n = 1'b1;
    sclk = 1'b0;
    sdata = 1'b0;
  end

  // one 16-bit frame, 320 ns clock, read bits caught on falling edges
  task automatic frame(input logic [7:0] addr, input logic [7:0] data,
                       output logic [7:0] rd);
    logic [15:0] bits;
    bits = {addr, data};
    #13 sen_n = 1'b0;
    #100;
    for (int i = 0; i < 16; i++) begin
      sdata = bits[15 - i];
      #120 sclk = 1'b1;
      #200;
      if (i > 6 && i < 15) rd[14 - i] = sdo;
      sclk = 1'b0;
    end
    #100 sen_n = 1'b1;
    sdata = ~sdata;
    #200;
  endtask : frame
endmodule : acr_host

// ===== verif/acr_top_tb.sv
// self-checking bench for the configuration bank
`timescale 1ns/1ps
module acr_top_tb;
  logic clk, resetn, raw_valid, data_ready, raw_ready, data_valid;
  logic sdo_o, sdo_oe, cmos_sel, cha_oe, chb_oe, clk_oe;
  logic ddrv, ofs_on, standby_and_drive_strength, awake;
  logic [13:0] cha_raw, chb_raw, cha_data, chb_data;
  logic [5:0] swing;
  logic [1:0] perf, sedrv, fall, rise;
  wire sen_n, sclk, sdata;
  wire sdo = sdo_oe ? sdo_o : 1'bz;
  int num_errors = 0;
  int n_checks = 0;

  acr_host i_host (.sen_n(sen_n), .sclk(sclk), .sdata(sdata), .sdo(sdo));
  acr_top #(.WAKE_CYCLES(40)) i_dut (
    .CLK(clk), .RESETN(resetn), .SEN_N(sen_n), .SCLK(sclk), .SDATA(sdata),
    .SERIAL_OUT_PIN_O(sdo_o), .SERIAL_OUT_PIN_OE(sdo_oe),
    .CHA_RAW(cha_raw), .CHB_RAW(chb_raw), .RAW_VALID(raw_valid),
    .RAW_READY(raw_ready), .CHA_DATA(cha_data), .CHB_DATA(chb_data),
    .DATA_VALID(data_valid), .DATA_READY(data_ready), .SWING_CODE(swing),
    .BEST_PERFORMANCE_MODE(perf), .CMOS_SEL(cmos_sel),
    .SINGLE_ENDED_CLOCK_DRIVE(sedrv), .CHA_OUT_OE(cha_oe),
    .CHB_OUT_OE(chb_oe), .CLKOUT_OE(clk_oe), .OUT_CLOCK_FALL_SHIFT(fall),
    .OUT_CLOCK_RISE_SHIFT(rise), .DIFF_CLOCK_DRIVE(ddrv),
    .OFFSET_FIX_ON(ofs_on), .STANDBY(standby_and_drive_strength), .AWAKE(awake));

  // 25 MHz clock
  always #20 clk = ~clk;

  task automatic check(input logic [19:0] seen, input logic [19:0] exp);
    n_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] unused;
    i_host.frame(a, d, unused);
  endtask : wr

  task automatic xfer(input logic [13:0] a, input logic [13:0] b,
                      output logic [13:0] oa, output logic [13:0] ob);
    int n;
    n = 0;
    @(posedge clk);
    raw_valid <= 1'b1;
    cha_raw <= a;
    chb_raw <= b;
    do @(posedge clk); while (raw_ready !== 1'b1 && ++n < 50);
    raw_valid <= 1'b0;
    do @(posedge clk); while (data_valid !== 1'b1 && ++n < 50);
    oa = cha_data;
    ob = chb_data;
  endtask : xfer

  task automatic t_defaults;
    check({swing, perf, cmos_sel, sedrv, fall, rise}, 0);
    check({ddrv, ofs_on, standby_and_drive_strength}, 0);
    check({cha_oe, chb_oe, clk_oe, awake, sdo_oe}, 5'h1e);
  endtask : t_defaults

  task automatic t_buffer;
    logic [13:0] v, got [2];
    int acc, k, n;
    acc = 0;
    k = 0;
    n = 0;
    v = 14'h0011;
    @(posedge clk);
    data_ready <= 1'b0;
    raw_valid <= 1'b1;
    cha_raw <= v;
    repeat (6) begin
      @(posedge clk);
      if (raw_ready === 1'b1) begin
        acc++;
        v = v + 14'h0001;
        cha_raw <= v;
      end
    end
    raw_valid <= 1'b0;
    data_ready <= 1'b1;
    while (k < 2 && n++ < 20) begin
      @(posedge clk);
      if (data_valid === 1'b1) got[k++] = cha_data;
    end
    check(acc, 2);
    check(got[0], 14'h0011);
    check(got[1], 14'h0012);
  endtask : t_buffer

  task automatic t_standby;
    int n;
    n = 0;
    wr(8'h45, 8'h80);
    check({standby_and_drive_strength, raw_ready}, 2'h2);
    wr(8'h45, 8'h00);
    check(awake, 1'b0);
    while (awake !== 1'b1 && n++ < 60) @(posedge clk);
    check(awake, 1'b1);
  endtask : t_standby

  task automatic t_fields;
    logic [1:0] c;
    wr(8'hf1, 8'h03);
    wr(8'h01, 8'h6c);
    check(swing, 6'h1b);
    wr(8'h01, 8'hf8);
    check(swing, 6'h3e);
    wr(8'h03, 8'h03);
    check(perf, 2'h3);
    for (int i = 0; i < 4; i++) begin
      c = 2'(i);
      wr(8'h41, {2'h2, c, 2'h0, c});
      check({cmos_sel, sedrv, cha_oe, chb_oe, clk_oe},
            {1'b0, c, ~c[1], ~c[0], ~&c});
      wr(8'h42, {c, c, 4'h0});
      check({fall, rise}, {c, c});
    end
    wr(8'h41, 8'hc0);
    check(cmos_sel, 1'b1);
    wr(8'h45, 8'h40);
    check({ddrv, standby_and_drive_strength}, 2'h2);
    wr(8'h3d, 8'h20);
    check(ofs_on, 1'b0);
    wr(8'h42, 8'h08);
    check(ofs_on, 1'b1);
    wr(8'h3d, 8'h00);
    check(ofs_on, 1'b0);
  endtask : t_fields

  task automatic t_patterns;
    logic [13:0] a, b, a2, b2, e;
    logic [2:0] p;
    wr(8'h3f, 8'h2d);
    wr(8'h40, 8'h96);
    for (int i = 0; i < 4; i++) begin
      p = (i == 3) ? 3'h5 : 3'(i);
      wr(8'h25, {5'h00, p});
      wr(8'h2b, {5'h00, p});
      xfer(14'h0123, 14'h3210, a, b);
      e = (p == 3'h0) ? 14'h0123 : (p == 3'h1) ? 14'h0000 :
          (p == 3'h2) ? 14'h3fff : 14'h2d96;
      check(a, e);
      check(b, (p == 3'h0) ? 14'h3210 : e);
    end
    wr(8'h25, 8'h03);
    wr(8'h2b, 8'h04);
    xfer(14'h0123, 14'h0123, a, b);
    xfer(14'h0123, 14'h0123, a2, b2);
    check(a === 14'h2aaa || a === 14'h1555, 1'b1);
    check(a2, {~a});
    check(b2, 14'(b + 14'h0001));
    wr(8'h2b, 8'h00);
    wr(8'h25, 8'hc0);
    xfer(14'd1000, 14'd1000, a, b);
    check(a > 14'd1993 && a < 14'd1998, 1'b1);
    check(b, 14'd1000);
    wr(8'h25, 8'h00);
    wr(8'h29, 8'h18);
    xfer(14'h0123, 14'h0123, a, b);
    check(a, 14'h2123);
    wr(8'h29, 8'h10);
    wr(8'h25, 8'hc1);
    wr(8'h42, 8'h00);
    xfer(14'h0123, 14'h0123, a, b);
    check(a, 14'h0123);
  endtask : t_patterns

  task automatic t_readout;
    logic [7:0] v;
    wr(8'h41, 8'hc3);
    wr(8'h00, 8'h02);
    check({cmos_sel, cha_oe, clk_oe}, 3'h3);
    wr(8'h41, 8'hf3);
    wr(8'h40, 8'ha5);
    wr(8'h00, 8'h01);
    check(sdo_oe, 1'b1);
    i_host.frame(8'h41, 8'h00, v);
    check(v, 8'hf3);
    i_host.frame(8'h40, 8'h00, v);
    check(v, 8'ha5);
    i_host.frame(8'h1f, 8'h00, v);
    check(v, 8'h00);
    // leave readout through the reset pin
    @(posedge clk);
    resetn <= 1'b0;
    repeat (2) @(posedge clk);
    resetn <= 1'b1;
    repeat (6) @(posedge clk);
    check({sdo_oe, cmos_sel}, 2'h0);
  endtask : t_readout

  task automatic complete_run;
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : complete_run

  // main sequence
  initial begin
    clk = 1'b0;
    resetn = 1'b0;
    raw_valid = 1'b0;
    data_ready = 1'b1;
    cha_raw = 14'h0000;
    chb_raw = 14'h0000;
    repeat (10) @(posedge clk);
    resetn <= 1'b1;
    repeat (6) @(posedge clk);
    t_defaults();
    t_buffer();
    t_standby();
    t_fields();
    t_patterns();
    t_readout();
    complete_run();
  end

  // watchdog
  initial begin
    #3000000;
    num_errors++;
    complete_run();
  end
endmodule : acr_top_tb
